// ==== pkg/plsl_cfg.svh ====
`ifndef PLSL_CFG_SVH
`define PLSL_CFG_SVH

// timing
`define CLK_PERIOD_NS    4
`define STRAP_SETTLE_NS  12
`define BLINK_NS         40000000

// register indices, byte address is four times the index
`define IDX_CTRL      8'h00
`define IDX_ADVERT    8'h04
`define IDX_STRAP     8'h10
`define IDX_INT       8'h1b
`define IDX_LEDCTL    8'h1e
`define IDX_CTRL2     8'h1f

// register bit positions
`define CTRL_SPEED    13
`define CTRL_ANEG     12
`define CTRL_ISO      10
`define CTRL_DUPLEX   8
`define ADV_100_LSB   7
`define ADV_100_MSB   8
`define INT_EN_LSB    8
`define INT_EV_W      3
`define LED_MODE_LSB  14
`define LED_MODE_MSB  15
`define CTRL2_POL     9
`define STRAP_DONE    16

// interrupt events
`define EV_LINK_UP    0
`define EV_LINK_DOWN  1
`define EV_SPEED      2

// strap vector positions
`define SP_DUPLEX     0
`define SP_ADDR2      1
`define SP_ADDR1      2
`define SP_ADDR0      3
`define SP_CFG2       4
`define SP_ISO        5
`define SP_CFG0       6
`define SP_CFG1       7
`define SP_ANEG       8
`define SP_SPEED      9
`define SP_W          10

// reset values
`define RST_CTRL      16'h3100
`define RST_ADVERT    16'h0180
`define RST_ADDR      5'h01
`define RST_IFMODE    3'h0

// interface mode codes
`define IFM_MII       3'h0
`define IFM_RESTORE   3'h4
`define IFM_B2B       3'h6

// led modes
`define LED_LINK_ACT  2'h0
`define LED_LINK_ONLY 2'h1

`endif

// ==== pkg/plsl_pkg.sv ====
package plsl_pkg;

    typedef enum logic [1:0] {
        ST_SETTLE,
        ST_CHECK,
        ST_RUN
    } plsl_state_t;

    typedef logic [2:0] plsl_iface_mode_t;
    typedef logic [1:0] plsl_led_mode_t;

endpackage

// ==== hw/plsl_top.sv ====
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`include "plsl_cfg.svh"
module plsl_top #(
    parameter int unsigned BLINK_CYCLES = `BLINK_NS / `CLK_PERIOD_NS,
    parameter int unsigned BLINK_W      = 24
) (
    // clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // ahb-lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // receive data pins, strap inputs during reset
    input  wire logic [3:0]              rxd_i,
    output logic      [3:0]              rxd_o,
    output logic      [3:0]              rxd_oe,
    input  wire logic                    rxdv_i,
    output logic                         rxdv_o,
    output logic                         rxdv_oe,
    input  wire logic                    rxer_i,
    output logic                         rxer_o,
    output logic                         rxer_oe,
    input  wire logic                    col_i,
    output logic                         col_o,
    output logic                         col_oe,
    input  wire logic                    crs_i,
    output logic                         crs_o,
    output logic                         crs_oe,
    // indicator pins, strap inputs during reset
    input  wire logic                    link_activity_indicator_i,
    output logic                         link_activity_indicator_o,
    output logic                         link_activity_indicator_oe,
    input  wire logic                    speed_activity_indicator_i,
    output logic                         speed_activity_indicator_o,
    output logic                         speed_activity_indicator_oe,
    // interrupt pin
    output logic                         interrupt_output,
    // mii transmit pins
    input  wire logic                    mii_tx_en,
    input  wire logic [3:0]              mii_txd,
    // device datapath
    input  wire logic [3:0]              rx_data,
    input  wire logic                    rx_valid,
    input  wire logic                    rx_error,
    input  wire logic                    col_det,
    input  wire logic                    crs_det,
    input  wire logic                    link_up,
    input  wire logic                    speed_100_stat,
    input  wire logic                    activity,
    output logic      [3:0]              tx_data,
    output logic                         tx_en,
    // strapped configuration
    output logic                         strap_done,
    output logic      [4:0]              mgmt_addr,
    output plsl_pkg::plsl_iface_mode_t   iface_mode,
    output logic                         iface_mode_reserved,
    output logic                         isolate,
    output logic                         speed_sel_100,
    output logic                         autoneg_en,
    output logic                         duplex_half
);
    import plsl_pkg::*;

    localparam int unsigned SETTLE_CYC =
        (`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    function automatic logic [7:0] reg_idx(input logic [31:0] a);
        reg_idx = a[9:2];
    endfunction

    function automatic logic in_map(input logic [31:0] a);
        logic [7:0] i;
        i = reg_idx(a);
        in_map = (a[31:10] == 22'h0) && (i == `IDX_CTRL ||
                 i == `IDX_ADVERT || i == `IDX_STRAP || i == `IDX_INT ||
                 i == `IDX_LEDCTL || i == `IDX_CTRL2);
    endfunction

    // ---------------- pin synchronisers ----------------
    logic [`SP_W-1:0] sp1_q, sp2_q, sp3_q;
    logic [4:0]       tx1_q, tx2_q, tx3_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp1_q <= '0;
            sp2_q <= '0;
            sp3_q <= '0;
            tx1_q <= '0;
            tx2_q <= '0;
            tx3_q <= '0;
        end else begin
            sp1_q <= {speed_activity_indicator_i, link_activity_indicator_i,
                      crs_i, col_i, rxer_i, rxdv_i, rxd_i};
            sp2_q <= sp1_q;
            sp3_q <= sp2_q;
            tx1_q <= {mii_tx_en, mii_txd};
            tx2_q <= tx1_q;
            tx3_q <= tx2_q;
        end
    end

    // ---------------- strap capture ----------------
    plsl_state_t      st_q, st_d;
    logic [3:0]       settle_q, settle_d;
    logic [2:0]       addr_q, addr_d;
    plsl_iface_mode_t ifm_q, ifm_d;
    logic             capture;

    always_comb begin
        st_d     = st_q;
        settle_d = settle_q;
        capture  = 1'b0;
        unique case (st_q)
            ST_SETTLE: begin
                settle_d = settle_q + 4'h1;
                if (settle_q == 4'(SETTLE_CYC)) begin
                    st_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (sp2_q == sp3_q) begin
                    capture = 1'b1;
                    st_d    = ST_RUN;
                end
            end
            ST_RUN: begin
                st_d = ST_RUN;
            end
        endcase
        addr_d = addr_q;
        ifm_d  = ifm_q;
        if (capture) begin
            addr_d = {sp3_q[`SP_ADDR2], sp3_q[`SP_ADDR1], sp3_q[`SP_ADDR0]};
            ifm_d  = {sp3_q[`SP_CFG2], sp3_q[`SP_CFG1], sp3_q[`SP_CFG0]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q     <= ST_SETTLE;
            settle_q <= '0;
            addr_q   <= 3'(`RST_ADDR);
            ifm_q    <= `RST_IFMODE;
        end else begin
            st_q     <= st_d;
            settle_q <= settle_d;
            addr_q   <= addr_d;
            ifm_q    <= ifm_d;
        end
    end

    // ---------------- ahb-lite slave ----------------
    logic        wr_q, wr_d;
    logic        rd_q, rd_d;
    logic [7:0]  aidx_q, aidx_d;
    logic        amap_q, amap_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic        hready_q, hready_d;
    logic        take;

    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] adv_q, adv_d;
    logic [`INT_EV_W-1:0] ist_q, ist_d;
    logic [`INT_EV_W-1:0] ien_q, ien_d;
    logic [15:0] ledctl_q, ledctl_d;
    logic [15:0] ctrl2_q, ctrl2_d;
    logic [`INT_EV_W-1:0] ev;
    logic        wr_now;

    assign take   = hsel && htrans[1] && hready;
    assign wr_now = wr_q && amap_q;

    function automatic logic [31:0] rd_mux(input logic [7:0] i);
        rd_mux = 32'h0;
        unique case (i)
            `IDX_CTRL:   rd_mux = {16'h0, ctrl_q};
            `IDX_ADVERT: rd_mux = {16'h0, adv_q};
            `IDX_STRAP:  rd_mux = {15'h0, (st_q == ST_RUN),
                                   5'h0, ifm_q, 3'h0, 2'b00, addr_q};
            `IDX_INT:    rd_mux = {16'h0, 5'h0, ien_q, 5'h0, ist_q};
            `IDX_LEDCTL: rd_mux = {16'h0, ledctl_q};
            `IDX_CTRL2:  rd_mux = {16'h0, ctrl2_q};
            default:     rd_mux = 32'h0;
        endcase
    endfunction

    always_comb begin
        wr_d     = 1'b0;
        rd_d     = 1'b0;
        aidx_d   = aidx_q;
        amap_d   = amap_q;
        hrdata_d = hrdata_q;
        hready_d = 1'b1;
        if (take) begin
            wr_d   = hwrite;
            rd_d   = !hwrite;
            aidx_d = reg_idx(haddr);
            amap_d = in_map(haddr);
            if (!hwrite) begin
                // one wait state so a read sees a write just before it
                hready_d = 1'b0;
            end
        end
        if (rd_q) begin
            hrdata_d = amap_q ? rd_mux(aidx_q) : 32'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            aidx_q   <= '0;
            amap_q   <= 1'b0;
            hrdata_q <= '0;
            hready_q <= 1'b1;
        end else begin
            wr_q     <= wr_d;
            rd_q     <= rd_d;
            aidx_q   <= aidx_d;
            amap_q   <= amap_d;
            hrdata_q <= hrdata_d;
            hready_q <= hready_d;
        end
    end

    // ---------------- registers ----------------
    logic link_p_q, spd_p_q;

    always_comb begin
        ev = '0;
        ev[`EV_LINK_UP]   = link_up && !link_p_q;
        ev[`EV_LINK_DOWN] = !link_up && link_p_q;
        ev[`EV_SPEED]     = link_up && (speed_100_stat != spd_p_q);
        ctrl_d   = ctrl_q;
        adv_d    = adv_q;
        ien_d    = ien_q;
        ledctl_d = ledctl_q;
        ctrl2_d  = ctrl2_q;
        ist_d    = ist_q;
        if (wr_now) begin
            unique case (aidx_q)
                `IDX_CTRL:   ctrl_d   = hwdata[15:0];
                `IDX_ADVERT: adv_d    = hwdata[15:0];
                `IDX_INT: begin
                    ien_d = hwdata[`INT_EN_LSB +: `INT_EV_W];
                    ist_d = ist_q & ~hwdata[`INT_EV_W-1:0];
                end
                `IDX_LEDCTL: ledctl_d = hwdata[15:0];
                `IDX_CTRL2:  ctrl2_d  = hwdata[15:0];
                default:     ctrl_d   = ctrl_q;
            endcase
        end
        ist_d = ist_d | ev;
        if (capture) begin
            ctrl_d[`CTRL_ISO]    = sp3_q[`SP_ISO];
            ctrl_d[`CTRL_SPEED]  = sp3_q[`SP_SPEED];
            ctrl_d[`CTRL_DUPLEX] = sp3_q[`SP_DUPLEX];
            ctrl_d[`CTRL_ANEG]   = sp3_q[`SP_ANEG];
            adv_d[`ADV_100_MSB:`ADV_100_LSB] = {2{sp3_q[`SP_SPEED]}};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q   <= `RST_CTRL;
            adv_q    <= `RST_ADVERT;
            ien_q    <= '0;
            ist_q    <= '0;
            ledctl_q <= '0;
            ctrl2_q  <= '0;
            link_p_q <= 1'b0;
            spd_p_q  <= 1'b0;
        end else begin
            ctrl_q   <= ctrl_d;
            adv_q    <= adv_d;
            ien_q    <= ien_d;
            ist_q    <= ist_d;
            ledctl_q <= ledctl_d;
            ctrl2_q  <= ctrl2_d;
            link_p_q <= link_up;
            spd_p_q  <= speed_100_stat;
        end
    end

    // ---------------- indicators ----------------
    logic [BLINK_W-1:0] bcnt_q, bcnt_d;
    logic               blink_q, blink_d;
    plsl_led_mode_t     lmode;
    logic               link_activity_indicator_d, speed_activity_indicator_d;

    assign lmode = ledctl_q[`LED_MODE_MSB:`LED_MODE_LSB];

    always_comb begin
        bcnt_d  = '0;
        blink_d = 1'b0;
        if (activity) begin
            bcnt_d  = bcnt_q + 1'b1;
            blink_d = blink_q;
            if (bcnt_q == BLINK_W'(BLINK_CYCLES - 1)) begin
                bcnt_d  = '0;
                blink_d = !blink_q;
            end
        end
        link_activity_indicator_d = 1'b1;
        speed_activity_indicator_d = 1'b1;
        unique case (lmode)
            `LED_LINK_ACT: begin
                link_activity_indicator_d = !link_up ? 1'b1 : (activity && blink_q);
                speed_activity_indicator_d = !speed_100_stat;
            end
            `LED_LINK_ONLY: begin
                link_activity_indicator_d = !link_up;
                speed_activity_indicator_d = !(activity && blink_q);
            end
            default: begin
                link_activity_indicator_d = 1'b1;
                speed_activity_indicator_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bcnt_q  <= '0;
            blink_q <= 1'b0;
        end else begin
            bcnt_q  <= bcnt_d;
            blink_q <= blink_d;
        end
    end

    // ---------------- pins and outputs ----------------
    logic       run;
    logic       mii_oe;
    logic [4:0] tx_ok;
    logic [4:0] txs_q, txs_d;
    logic       irq_act;

    assign run     = (st_q == ST_RUN);
    assign mii_oe  = run && !ctrl_q[`CTRL_ISO];
    assign tx_ok   = ~(tx2_q ^ tx3_q);
    assign irq_act = |(ist_q & ien_q);

    always_comb begin
        txs_d = (tx3_q & tx_ok) | (txs_q & ~tx_ok);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txs_q                       <= '0;
            rxd_o                       <= '0;
            rxd_oe                      <= '0;
            rxdv_o                      <= 1'b0;
            rxdv_oe                     <= 1'b0;
            rxer_o                      <= 1'b0;
            rxer_oe                     <= 1'b0;
            col_o                       <= 1'b0;
            col_oe                      <= 1'b0;
            crs_o                       <= 1'b0;
            crs_oe                      <= 1'b0;
            link_activity_indicator_o   <= 1'b1;
            link_activity_indicator_oe  <= 1'b0;
            speed_activity_indicator_o  <= 1'b1;
            speed_activity_indicator_oe <= 1'b0;
            interrupt_output            <= 1'b1;
            tx_data                     <= '0;
            tx_en                       <= 1'b0;
        end else begin
            txs_q                       <= txs_d;
            rxd_o                       <= rx_valid ? rx_data : 4'h0;
            rxd_oe                      <= {4{mii_oe}};
            rxdv_o                      <= rx_valid;
            rxdv_oe                     <= mii_oe;
            rxer_o                      <= rx_error;
            rxer_oe                     <= mii_oe;
            col_o                       <= col_det;
            col_oe                      <= mii_oe;
            crs_o                       <= crs_det;
            crs_oe                      <= mii_oe;
            link_activity_indicator_o   <= link_activity_indicator_d;
            link_activity_indicator_oe  <= run;
            speed_activity_indicator_o  <= speed_activity_indicator_d;
            speed_activity_indicator_oe <= run;
            interrupt_output            <= ctrl2_q[`CTRL2_POL] ? irq_act : !irq_act;
            tx_en                       <= txs_q[4] && !ctrl_q[`CTRL_ISO];
            tx_data                     <= (txs_q[4] && !ctrl_q[`CTRL_ISO]) ? txs_q[3:0] : 4'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_done          <= 1'b0;
            mgmt_addr           <= `RST_ADDR;
            iface_mode          <= `RST_IFMODE;
            iface_mode_reserved <= 1'b0;
            isolate             <= 1'b0;
            speed_sel_100       <= 1'b1;
            autoneg_en          <= 1'b1;
            duplex_half         <= 1'b1;
        end else begin
            strap_done          <= run;
            mgmt_addr           <= {2'b00, addr_q};
            iface_mode          <= ifm_q;
            iface_mode_reserved <= !(ifm_q == `IFM_MII || ifm_q == `IFM_RESTORE ||
                                     ifm_q == `IFM_B2B);
            isolate             <= ctrl_q[`CTRL_ISO];
            speed_sel_100       <= ctrl_q[`CTRL_SPEED];
            autoneg_en          <= ctrl_q[`CTRL_ANEG];
            duplex_half         <= ctrl_q[`CTRL_DUPLEX];
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = hready_q;
    assign hresp     = 1'b0;

endmodule

// ==== tb/plsl_top_assertions.sv ====
`timescale 1ns/1ns
module plsl_top_checker (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // register bus
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    // pins and datapath
    input wire logic [3:0] rxd_o,
    input wire logic [3:0] rxd_oe,
    input wire logic [3:0] rx_data,
    input wire logic       rx_valid,
    input wire logic [3:0] tx_data,
    input wire logic       tx_en,
    input wire logic       link_activity_indicator_oe,
    input wire logic       interrupt_output,
    // strapped configuration
    input wire logic       strap_done,
    input wire logic [4:0] mgmt_addr,
    input wire logic [2:0] iface_mode,
    input wire logic       iface_mode_reserved
);
    import plsl_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_addr_top_zero: assert property (mgmt_addr[4:3] == 2'b00)
        else $error("address top bits set");
    a_straps_held: assert property (strap_done && $past(strap_done) |-> $stable(mgmt_addr) && $stable(iface_mode))
        else $error("straps changed after capture");
    a_pins_in_reset: assert property (!strap_done |-> rxd_oe == 4'h0 && !link_activity_indicator_oe)
        else $error("strap pin driven before capture");
    a_pins_driven: assert property ($rose(strap_done) |-> link_activity_indicator_oe ##1 link_activity_indicator_oe)
        else $error("indicator not driven");
    a_rx_idle_zero: assert property (strap_done && !$past(rx_valid) |-> rxd_o == 4'h0)
        else $error("rx data not zero");
    a_rx_passes: assert property (strap_done && rx_valid |=> rxd_o == $past(rx_data))
        else $error("rx data not passed");
    a_tx_ignored: assert property (!tx_en |-> tx_data == 4'h0)
        else $error("tx data leaked");
    a_mode_reserved: assert property (strap_done |-> iface_mode_reserved == !(iface_mode inside {3'h0, 3'h4, 3'h6}))
        else $error("reserved mode flag wrong");
    a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    c_strap: cover property ($rose(strap_done));
    c_irq: cover property ($fell(interrupt_output));
    c_read: cover property (hsel && htrans[1] && hready && !hwrite);
endmodule

bind plsl_top plsl_top_checker u_chk (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .rxd_o, .rxd_oe, .rx_data, .rx_valid,
    .tx_data, .tx_en, .link_activity_indicator_oe, .interrupt_output, .strap_done, .mgmt_addr, .iface_mode,
    .iface_mode_reserved
);

// ==== tb/plsl_mac_model.sv ====
`timescale 1ns/1ns
module plsl_mac_model (
    // clock
    input  wire logic       hclk,
    // strap levels and device pins
    input  wire logic [9:0] strap,
    input  wire logic [9:0] pin_o,
    input  wire logic [9:0] pin_oe,
    output logic      [9:0] pin_i,
    // transmit frame request
    input  wire logic       tx_req,
    input  wire logic [3:0] tx_nib,
    output logic            mii_tx_en,
    output logic      [3:0] mii_txd
);
    // released pins fall back to the pull or strap level
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & strap);
    initial {mii_tx_en, mii_txd} = 5'h00;
    // outside a frame the data lines carry a changing pattern
    always @(posedge hclk) begin
        mii_tx_en <= tx_req;
        mii_txd <= tx_req ? tx_nib : ~mii_txd;
    end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`include "plsl_cfg.svh"
module testbench;
    import plsl_pkg::*;
    localparam logic [31:0] A_CTRL = 4 * `IDX_CTRL;
    localparam logic [31:0] A_ADV  = 4 * `IDX_ADVERT;
    localparam logic [31:0] A_INT  = 4 * `IDX_INT;
    localparam logic [31:0] A_LED  = 4 * `IDX_LEDCTL;
    localparam logic [31:0] A_CTL2 = 4 * `IDX_CTRL2;
    logic             hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, tx_req;
    logic [31:0]      haddr, hwdata, hrdata, r;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic [3:0]       rxd_o, rxd_oe, rx_data, tx_data, mii_txd, tx_nib;
    wire logic [3:0]  rxd_i;
    wire logic        rxdv_i, rxer_i, col_i, crs_i, link_activity_indicator_i, speed_activity_indicator_i;
    logic             rxdv_o, rxdv_oe, rxer_o, rxer_oe, col_o, col_oe, crs_o, crs_oe;
    logic             link_activity_indicator_o, link_activity_indicator_oe;
    logic             speed_activity_indicator_o, speed_activity_indicator_oe;
    logic             interrupt_output, mii_tx_en, rx_valid, rx_error, col_det, crs_det, link_up, speed_100_stat;
    logic             activity, tx_en, strap_done, iface_mode_reserved, isolate, speed_sel_100, autoneg_en, duplex_half;
    logic [4:0]       mgmt_addr;
    plsl_iface_mode_t iface_mode;
    logic [9:0]       strap;
    logic [9:0]       cases [4] = '{10'h03e, 10'h39a, 10'h040, 10'h309};
    int               miscompares, num_checks;

    plsl_top #(.BLINK_CYCLES(4)) u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .rxd_i, .rxd_o, .rxd_oe, .rxdv_i, .rxdv_o, .rxdv_oe, .rxer_i, .rxer_o, .rxer_oe, .col_i, .col_o, .col_oe,
        .crs_i, .crs_o, .crs_oe, .link_activity_indicator_i, .link_activity_indicator_o, .link_activity_indicator_oe,
        .speed_activity_indicator_i, .speed_activity_indicator_o, .speed_activity_indicator_oe, .interrupt_output,
        .mii_tx_en, .mii_txd, .rx_data, .rx_valid, .rx_error, .col_det, .crs_det, .link_up, .speed_100_stat,
        .activity, .tx_data, .tx_en, .strap_done, .mgmt_addr, .iface_mode, .iface_mode_reserved, .isolate,
        .speed_sel_100, .autoneg_en, .duplex_half
    );
    plsl_mac_model u_mac (
        .hclk, .strap, .tx_req, .tx_nib, .mii_tx_en, .mii_txd,
        .pin_o ({speed_activity_indicator_o, link_activity_indicator_o, crs_o, col_o, rxer_o, rxdv_o, rxd_o}),
        .pin_oe({speed_activity_indicator_oe, link_activity_indicator_oe, crs_oe, col_oe, rxer_oe, rxdv_oe, rxd_oe}),
        .pin_i ({speed_activity_indicator_i, link_activity_indicator_i, crs_i, col_i, rxer_i, rxdv_i, rxd_i})
    );
    assign hready = hreadyout;

    task automatic chk(input logic [31:0] g, e, input string m);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic t_strap(input logic [9:0] s);
        logic [2:0] m;
        m = {s[4], s[7], s[6]};
        strap <= s;
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (40) if (strap_done !== 1'b1) @(posedge hclk);
        @(posedge hclk);
        strap <= ~s;
        chk(strap_done, 1, "strap done");
        chk(mgmt_addr, {s[1], s[2], s[3]}, "address");
        chk(iface_mode, m, "mode");
        chk(iface_mode_reserved, !(m inside {`IFM_MII, `IFM_RESTORE, `IFM_B2B}), "mode reserved");
        chk({isolate, speed_sel_100, duplex_half, autoneg_en}, {s[5], s[9], s[0], s[8]}, "levels");
        chk(rxd_oe, {4{!s[5]}}, "rx pins driven");
        chk(speed_activity_indicator_oe, 1, "indicator driven");
        bus(0, A_CTRL, 0);
        chk(r[15:0], {2'b00, s[9], s[8], 1'b0, s[5], 1'b0, s[0], 8'h00}, "control");
        bus(0, A_ADV, 0);
        chk(r[8:7], {2{s[9]}}, "advert");
    endtask

    task automatic t_irq();
        bus(1, A_INT, 32'h100);
        link_up <= 1'b1;
        repeat (4) @(posedge hclk);
        chk(interrupt_output, 0, "irq active low");
        bus(0, A_INT, 0);
        chk(r[10:0], 11'h101, "irq status");
        bus(1, A_INT, 32'h101);
        repeat (2) @(posedge hclk);
        chk(interrupt_output, 1, "irq cleared");
        bus(1, A_INT, 32'h0);
        link_up <= 1'b0;
        repeat (4) @(posedge hclk);
        chk(interrupt_output, 1, "irq masked");
        bus(1, A_CTL2, 32'h200);
        repeat (2) @(posedge hclk);
        chk(interrupt_output, 0, "irq idle high");
        bus(1, A_INT, 32'h200);
        repeat (2) @(posedge hclk);
        chk(interrupt_output, 1, "irq active high");
        bus(1, A_INT, 32'h202);
        repeat (2) @(posedge hclk);
        chk(interrupt_output, 0, "irq cleared high");
    endtask

    task automatic blink(input logic sel);
        logic [1:0] seen;
        seen = 2'b00;
        repeat (16) begin
            @(posedge hclk);
            seen[sel ? speed_activity_indicator_o : link_activity_indicator_o] = 1'b1;
        end
        chk(seen, 2'b11, "indicator blink");
    endtask

    task automatic t_led();
        bus(1, A_LED, 32'h0);
        repeat (3) @(posedge hclk);
        chk({link_activity_indicator_o, speed_activity_indicator_o}, 2'b10, "no link 100M");
        link_up <= 1'b1;
        speed_100_stat <= 1'b0;
        repeat (3) @(posedge hclk);
        chk({link_activity_indicator_o, speed_activity_indicator_o}, 2'b01, "link 10M");
        activity <= 1'b1;
        blink(0);
        bus(1, A_LED, 32'h4000);
        blink(1);
        chk(link_activity_indicator_o, 0, "link only");
        activity <= 1'b0;
        link_up <= 1'b0;
        repeat (3) @(posedge hclk);
        chk({link_activity_indicator_o, speed_activity_indicator_o}, 2'b11, "no link idle");
        link_up <= 1'b1;
        bus(1, A_LED, 32'hc000);
        repeat (3) @(posedge hclk);
        chk({link_activity_indicator_o, speed_activity_indicator_o}, 2'b11, "reserved mode");
    endtask

    task automatic t_dp();
        {rx_valid, rx_error, col_det, crs_det} <= 4'hf;
        rx_data <= 4'ha;
        repeat (2) @(posedge hclk);
        chk({crs_o, col_o, rxer_o, rxdv_o, rxd_o}, 8'hfa, "rx data");
        {rx_valid, rx_error, col_det, crs_det} <= 4'h0;
        repeat (2) @(posedge hclk);
        chk({crs_o, col_o, rxer_o, rxdv_o, rxd_o}, 0, "rx idle");
        tx_req <= 1'b1;
        tx_nib <= 4'h5;
        repeat (8) @(posedge hclk);
        chk({tx_en, tx_data}, 5'h15, "tx frame");
        tx_req <= 1'b0;
        repeat (8) @(posedge hclk);
        chk({tx_en, tx_data}, 5'h00, "tx idle");
        bus(1, 32'h20, 32'hffff);
        bus(0, 32'h20, 0);
        chk(r, 0, "unmapped");
        chk(hresp, 0, "okay");
    endtask

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        #100000;
        miscompares++;
        end_of_test();
    end
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {rx_valid, rx_error, col_det, crs_det, link_up, activity, tx_req, tx_nib, rx_data} = '0;
        hsize = 3'h2;
        speed_100_stat = 1'b1;
        strap = 10'h309;
        miscompares = 0;
        num_checks = 0;
        foreach (cases[i]) begin
            t_strap(cases[i]);
        end
        t_irq();
        t_led();
        t_dp();
        end_of_test();
    end
endmodule
